// File: hw/clk_out_defs.vh
// constants for the channel divider and output control block
// assumes inclusion by bare name from every file of the block
`ifndef CLK_OUT_DEFS_VH
`define CLK_OUT_DEFS_VH

// register indices; byte address is four times the index
`define IDX_W          10
`define IDX_DIV        10'h028
`define IDX_CTL        10'h029
`define IDX_STAT       10'h02A

// reset values
`define DIV_RST        8'h02
`define CTL_RST        8'h18

// control register field positions
`define SRC_HI         7
`define SRC_LO         6
`define FMT_HI         5
`define FMT_LO         4
`define MODEA_HI       3
`define MODEA_LO       2
`define MODEB_HI       1
`define MODEB_LO       0

// source select codes
`define SRC_SYN_ONE    2'h0
`define SRC_SYN_TWO    2'h1
`define SRC_REF_PRI    2'h2
`define SRC_REF_SEC    2'h3

// driver format codes
`define FMT_OFF        2'h0
`define FMT_DIFF       2'h1
`define FMT_HCSL       2'h2
`define FMT_CMOS       2'h3

// single-ended pin codes
`define PIN_HIZ        2'h0
`define PIN_LOW        2'h1
`define PIN_INV        2'h2
`define PIN_POS        2'h3

// tail current in mA, load in ohm
`define TAIL_4         5'h04
`define TAIL_6         5'h06
`define TAIL_8         5'h08
`define TAIL_16        5'h10
`define LOAD_OPEN      8'h00
`define LOAD_50        8'h32
`define LOAD_100       8'h64
`define LOAD_200       8'hC8

// bus answers
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`define DATA_ZERO      32'h0000_0000

`endif

// File: hw/div_counter.v
// divide-by-(n+1) counter driven by source clock ticks
// assumes src_tick is a one-cycle pulse per source period, synchronous to clk
`timescale 1ns/10ps
`default_nettype none
`include "clk_out_defs.vh"
module div_counter (
	input  wire       clk,        // core clock
	input  wire       resetn,     // async reset, low
	input  wire       src_tick,   // one pulse per source period
	input  wire       bypass,     // reference selected
	input  wire [7:0] div_val,    // programmed divide value
	output reg        out_tick,   // one pulse per output period
	output reg  [7:0] ratio_q     // divide value in force
);
	reg [7:0] count_q;

	// count source ticks, wrap at the applied value
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count_q  <= 8'h00;
			ratio_q  <= `DIV_RST;
			out_tick <= 1'b0;
		end else begin
			out_tick <= 1'b0;
			if (src_tick) begin
				if (bypass) begin
					out_tick <= 1'b1;
					count_q  <= 8'h00;
					ratio_q  <= div_val;
				end else if (count_q == ratio_q) begin
					out_tick <= 1'b1;
					count_q  <= 8'h00;
					ratio_q  <= div_val;
				end else begin
					count_q  <= count_q + 8'h01;
				end
			end
		end
	end
endmodule // div_counter
`default_nettype wire

// File: hw/drive_decode.v
// output driver decode from format and the two drive mode fields
// assumes level is the divided channel clock level; purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "clk_out_defs.vh"
module drive_decode (
	input  wire [1:0] fmt,        // driver format
	input  wire [1:0] drive_mode_a, // tail or positive pin code
	input  wire [1:0] drive_mode_b, // load or negative pin code
	input  wire       level,      // channel clock level
	output reg        p_out,      // positive pin value
	output reg        p_oe,       // positive pin driven
	output reg        p_pwr,      // positive driver powered
	output reg        n_out,      // negative pin value
	output reg        n_oe,       // negative pin driven
	output reg        n_pwr,      // negative driver powered
	output reg  [4:0] tail_ma,    // tail current, 0 when unused
	output reg  [7:0] load_ohm    // hcsl load, 0 when open
);
	// {powered, oe, value} for one single-ended pin
	function [2:0] pin_dec;
		input [1:0] code;
		input       lvl;
		begin
			case (code)
			`PIN_HIZ: pin_dec = 3'b000;
			`PIN_LOW: pin_dec = 3'b010;
			`PIN_INV: pin_dec = {2'b11, ~lvl};
			default:  pin_dec = {2'b11, lvl};
			endcase
		end
	endfunction

	// pins follow format; single-ended pins decoded per field
	always @* begin
		{p_pwr, p_oe, p_out} = 3'b000;
		{n_pwr, n_oe, n_out} = 3'b000;
		tail_ma  = 5'h00;
		load_ohm = `LOAD_OPEN;
		case (fmt)
		`FMT_CMOS: begin
			{p_pwr, p_oe, p_out} = pin_dec(drive_mode_a, level);
			{n_pwr, n_oe, n_out} = pin_dec(drive_mode_b, level);
		end
		`FMT_DIFF, `FMT_HCSL: begin
			{p_pwr, p_oe, p_out} = {2'b11, level};
			{n_pwr, n_oe, n_out} = {2'b11, ~level};
			case (drive_mode_a)
			2'h0:    tail_ma = `TAIL_4;
			2'h1:    tail_ma = `TAIL_6;
			2'h2:    tail_ma = `TAIL_8;
			default: tail_ma = (fmt == `FMT_HCSL) ? `TAIL_16 : `TAIL_8;
			endcase
			if (fmt == `FMT_HCSL) begin
				case (drive_mode_b)
				2'h0:    load_ohm = `LOAD_OPEN;
				2'h1:    load_ohm = `LOAD_50;
				2'h2:    load_ohm = `LOAD_100;
				default: load_ohm = `LOAD_200;
				endcase
			end
		end
		default: begin
			// output disabled, everything stays off
			tail_ma = 5'h00;
		end
		endcase
	end
endmodule // drive_decode
`default_nettype wire

// File: hw/output_channel_divider_mux.v
// one clock output channel: divider, source mux, driver controls, axi4-lite regs
// assumes source ticks are one-cycle pulses synchronous to core_clk
// and a bus master with at most one write and one read in flight
//
// How it works
// - the divide register is eight bits, read-write, and resets to 0x02.
// - the channel clock is the source divided by the divide value plus one.
// - the divider acts only for the two synthesizers; references pass straight.
// - bits 7:6 pick synthesizer one, two, primary or secondary reference, reset 0.
// - bits 5:4 pick disabled, ac differential, hcsl or lvcmos output.
// - bits 3:2, reset 2, set positive pin power and polarity in single-ended mode.
// - in differential mode bits 3:2 give 4, 6, 8 or 16/8 mA tail current.
// - bits 1:0, reset 0, set the negative pin or, for hcsl, the load.
`timescale 1ns/10ps
`default_nettype none
`include "clk_out_defs.vh"
module output_channel_divider_mux (
	input  wire        core_clk,          // 20 MHz core clock
	input  wire        resetn,            // async reset, low
	// axi4-lite write address
	input  wire [11:0] s_axi_awaddr,      // write byte address
	input  wire        s_axi_awvalid,     // write address valid
	output reg         s_axi_awready,     // write address ready
	// axi4-lite write data
	input  wire [31:0] s_axi_wdata,       // write data
	input  wire [3:0]  s_axi_wstrb,       // byte strobes
	input  wire        s_axi_wvalid,      // write data valid
	output reg         s_axi_wready,      // write data ready
	// axi4-lite write response
	output reg  [1:0]  s_axi_bresp,       // write response
	output reg         s_axi_bvalid,      // write response valid
	input  wire        s_axi_bready,      // write response ready
	// axi4-lite read
	input  wire [11:0] s_axi_araddr,      // read byte address
	input  wire        s_axi_arvalid,     // read address valid
	output reg         s_axi_arready,     // read address ready
	output reg  [31:0] s_axi_rdata,       // read data
	output reg  [1:0]  s_axi_rresp,       // read response
	output reg         s_axi_rvalid,      // read data valid
	input  wire        s_axi_rready,      // read data ready
	// clock sources, one tick per source period
	input  wire        synthesizer_one_tick, // synthesizer one
	input  wire        synthesizer_two_tick, // synthesizer two
	input  wire        ref_primary_tick,  // primary reference
	input  wire        ref_secondary_tick, // secondary reference
	// channel outputs
	output wire        chan_tick,         // divided clock, one pulse per period
	output reg         chan_level_q,      // divided clock level
	output reg         pin_p_out_q,       // positive pin value
	output reg         pin_p_oe_q,        // positive pin driven
	output reg         pin_p_pwr_q,       // positive driver powered
	output reg         pin_n_out_q,       // negative pin value
	output reg         pin_n_oe_q,        // negative pin driven
	output reg         pin_n_pwr_q,       // negative driver powered
	output reg  [4:0]  tail_ma_q,         // tail current in mA
	output reg  [7:0]  load_ohm_q         // hcsl load in ohm
);
	// write channel states, one-hot
	localparam [1:0] WS_IDLE = 2'b01;
	localparam [1:0] WS_RESP = 2'b10;

	reg  [1:0]  wstate_q;
	reg         aw_got_q;
	reg         w_got_q;
	reg  [9:0]  waddr_q;
	reg  [7:0]  wbyte_q;
	reg         wbyte_en_q;
	// high on the cycle a held write lands
	wire        wr_commit;

	// register contents
	reg  [7:0]  div_q;
	reg  [7:0]  ctl_q;

	// decoded fields
	wire [1:0]  channel_source_select;
	wire [1:0]  out_format;
	wire [1:0]  drive_mode_a;
	wire [1:0]  drive_mode_b;
	reg         src_tick;
	wire        bypass;
	wire [7:0]  ratio_q;

	// decode outputs before the output flops
	wire        p_out;
	wire        p_oe;
	wire        p_pwr;
	wire        n_out;
	wire        n_oe;
	wire        n_pwr;
	wire [4:0]  tail_ma;
	wire [7:0]  load_ohm;

	// word index from a byte address; low two bits ignored
	function [9:0] word_idx;
		input [11:0] addr;
		begin
			word_idx = addr[11:2];
		end
	endfunction

	// true for any index the block answers
	function idx_mapped;
		input [9:0] idx;
		begin
			idx_mapped = (idx == `IDX_DIV) || (idx == `IDX_CTL) ||
				(idx == `IDX_STAT);
		end
	endfunction

	// fields wired straight from the control register, no shadow copy
	// source select field
	assign channel_source_select = ctl_q[`SRC_HI:`SRC_LO];
	assign out_format   = ctl_q[`FMT_HI:`FMT_LO];
	assign drive_mode_a = ctl_q[`MODEA_HI:`MODEA_LO];
	assign drive_mode_b = ctl_q[`MODEB_HI:`MODEB_LO];

	assign bypass = (channel_source_select == `SRC_REF_PRI) ||
		(channel_source_select == `SRC_REF_SEC);

	// a source change mid-period is not resynchronised; the count carries on
	// source mux over the four tick inputs
	always @* begin
		case (channel_source_select)
		`SRC_SYN_ONE: src_tick = synthesizer_one_tick;
		`SRC_SYN_TWO: src_tick = synthesizer_two_tick;
		`SRC_REF_PRI: src_tick = ref_primary_tick;
		default:      src_tick = ref_secondary_tick;
		endcase
	end

	// divider; the applied ratio changes only when a period ends
	// bypass follows the source field, so references pass every tick
	div_counter u_div (
		.clk      (core_clk),
		.resetn   (resetn),
		.src_tick (src_tick),
		.bypass   (bypass),
		.div_val  (div_q),
		.out_tick (chan_tick),
		.ratio_q  (ratio_q)
	);

	// level toggles per divided tick, so it runs at half the tick rate
	// starts low after reset, so the first divided tick gives a rising level
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			chan_level_q <= 1'b0;
		end else if (chan_tick) begin
			chan_level_q <= ~chan_level_q;
		end
	end

	// driver controls from format and mode fields
	drive_decode u_drv (
		.fmt          (out_format),
		.drive_mode_a (drive_mode_a),
		.drive_mode_b (drive_mode_b),
		.level        (chan_level_q),
		.p_out        (p_out),
		.p_oe         (p_oe),
		.p_pwr        (p_pwr),
		.n_out        (n_out),
		.n_oe         (n_oe),
		.n_pwr        (n_pwr),
		.tail_ma      (tail_ma),
		.load_ohm     (load_ohm)
	);

	// pin controls registered so outputs come from flops
	// costs one cycle of lag behind the control register
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pin_p_out_q <= 1'b0;
			pin_p_oe_q  <= 1'b0;
			pin_p_pwr_q <= 1'b0;
			pin_n_out_q <= 1'b0;
			pin_n_oe_q  <= 1'b0;
			pin_n_pwr_q <= 1'b0;
			tail_ma_q   <= 5'h00;
			load_ohm_q  <= `LOAD_OPEN;
		end else begin
			pin_p_out_q <= p_out;
			pin_p_oe_q  <= p_oe;
			pin_p_pwr_q <= p_pwr;
			pin_n_out_q <= n_out;
			pin_n_oe_q  <= n_oe;
			pin_n_pwr_q <= n_pwr;
			tail_ma_q   <= tail_ma;
			load_ohm_q  <= load_ohm;
		end
	end

	// write channel: address and data taken in either order
	// ready stays low until the response is taken, so one write at most is in flight
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wstate_q      <= WS_IDLE;
			aw_got_q      <= 1'b0;
			w_got_q       <= 1'b0;
			waddr_q       <= 10'h000;
			wbyte_q       <= 8'h00;
			wbyte_en_q    <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
		end else begin
			case (wstate_q)
			WS_IDLE: begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_got_q      <= 1'b1;
					s_axi_awready <= 1'b0;
					waddr_q       <= word_idx(s_axi_awaddr);
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_got_q      <= 1'b1;
					s_axi_wready <= 1'b0;
					wbyte_q      <= s_axi_wdata[7:0];
					wbyte_en_q   <= s_axi_wstrb[0];
				end
				// both halves held: answer next cycle
				if (wr_commit) begin
					s_axi_bvalid <= 1'b1;
					s_axi_bresp  <= idx_mapped(waddr_q) ? `RESP_OKAY : `RESP_SLVERR;
					wstate_q     <= WS_RESP;
				end
			end
			WS_RESP: begin
				if (s_axi_bready) begin
					s_axi_bvalid  <= 1'b0;
					aw_got_q      <= 1'b0;
					w_got_q       <= 1'b0;
					s_axi_awready <= 1'b1;
					s_axi_wready  <= 1'b1;
					wstate_q      <= WS_IDLE;
				end
			end
			default: begin
				wstate_q <= WS_IDLE;
			end
			endcase
		end
	end

	assign wr_commit = (wstate_q == WS_IDLE) && aw_got_q && w_got_q;

	// register update when a held write completes; only lane 0 carries data
	// a write to a mapped index without lane 0 answers okay and leaves the register alone
	// the status index matches neither compare, so writes to it change nothing
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			div_q <= `DIV_RST;
			ctl_q <= `CTL_RST;
		end else if (wr_commit && wbyte_en_q) begin
			if (waddr_q == `IDX_DIV) begin
				div_q <= wbyte_q;
			end
			if (waddr_q == `IDX_CTL) begin
				ctl_q <= wbyte_q;
			end
		end
	end

	// read channel: data one cycle after the address is taken
	// the status word is read-only; unmapped reads give zero data and slverr
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= `DATA_ZERO;
			s_axi_rresp   <= `RESP_OKAY;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= `RESP_OKAY;
			case (word_idx(s_axi_araddr))
			`IDX_DIV:  s_axi_rdata <= {24'h00_0000, div_q};
			`IDX_CTL:  s_axi_rdata <= {24'h00_0000, ctl_q};
			// status shows the ratio in force and the source in use
			`IDX_STAT: s_axi_rdata <= {22'h00_0000, channel_source_select, ratio_q};
			default: begin
				s_axi_rdata <= `DATA_ZERO;
				s_axi_rresp <= `RESP_SLVERR;
			end
			endcase
		end
	end
endmodule // output_channel_divider_mux
`default_nettype wire

// File: sim/ocd_checker_assertions.sv
// concurrent checks on the channel divider block ports
// assumes bind onto output_channel_divider_mux, one clock domain
`timescale 1ns/10ps
`default_nettype none
module ocd_checker (
	input wire logic       core_clk,             // clock
	input wire logic       resetn,               // reset, low
	input wire logic       s_axi_awvalid,        // aw valid
	input wire logic       s_axi_awready,        // aw ready
	input wire logic       s_axi_wvalid,         // w valid
	input wire logic       s_axi_wready,         // w ready
	input wire logic       s_axi_bvalid,         // b valid
	input wire logic       s_axi_bready,         // b ready
	input wire logic       s_axi_arvalid,        // ar valid
	input wire logic       s_axi_arready,        // ar ready
	input wire logic       s_axi_rvalid,         // r valid
	input wire logic       s_axi_rready,         // r ready
	input wire logic       synthesizer_one_tick, // source tick
	input wire logic       synthesizer_two_tick, // source tick
	input wire logic       ref_primary_tick,     // source tick
	input wire logic       ref_secondary_tick,   // source tick
	input wire logic       chan_tick,            // divided tick
	input wire logic       chan_level_q,         // divided level
	input wire logic [4:0] tail_ma_q,            // tail current
	input wire logic [7:0] load_ohm_q            // hcsl load
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);

	// level moves exactly with divided ticks
	level_toggle_a: assert property (chan_tick |=> chan_level_q != $past(chan_level_q))
		else $error("level did not toggle on tick");
	level_hold_a: assert property (!chan_tick |=> $stable(chan_level_q))
		else $error("level moved without tick");
	// a divided tick always follows some source tick
	tick_cause_a: assert property (chan_tick |->
		$past(synthesizer_one_tick || synthesizer_two_tick || ref_primary_tick || ref_secondary_tick))
		else $error("divided tick without source tick");
	// bus answers at the fixed latencies
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write answer timing wrong");
	b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
		else $error("write response not released");
	r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read response not released");
	// driver settings stay within the coded values
	tail_legal_a: assert property (tail_ma_q inside {5'h00, 5'h04, 5'h06, 5'h08, 5'h10})
		else $error("tail current out of set");
	load_legal_a: assert property (load_ohm_q != 8'h00 |-> tail_ma_q != 5'h00
		&& load_ohm_q inside {8'h32, 8'h64, 8'hC8})
		else $error("load without differential drive");
endmodule // ocd_checker

bind output_channel_divider_mux ocd_checker i_ocd_checker (.core_clk, .resetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .synthesizer_one_tick, .synthesizer_two_tick, .ref_primary_tick, .ref_secondary_tick,
	.chan_tick, .chan_level_q, .tail_ma_q, .load_ohm_q);
`default_nettype wire

// File: sim/output_channel_divider_mux_tb_top.sv
// register-level bench for the channel divider block
// assumes the bound checker and a 20 MHz core clock
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module output_channel_divider_mux_tb_top;
	logic        core_clk = 0;
	logic        resetn = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0]  s_axi_wstrb = 0, tk = 0;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, chan_tick, chan_level_q;
	wire         pin_p_out_q, pin_p_oe_q, pin_p_pwr_q, pin_n_out_q, pin_n_oe_q, pin_n_pwr_q;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata;
	wire [4:0]   tail_ma_q;
	wire [7:0]   load_ohm_q;
	wire         synthesizer_one_tick = tk[0];
	wire         synthesizer_two_tick = tk[1];
	wire         ref_primary_tick = tk[2];
	wire         ref_secondary_tick = tk[3];
	int          miscompares = 0, num_checks = 0, cnt = 0, per = 0, ntk = 0, i, f, c;
	int          dv[3] = '{0, 2, 255};
	logic [7:0]  ld[4] = '{8'h00, 8'h32, 8'h64, 8'hC8};
	logic [1:0]  rsp;
	logic [31:0] rd;
	logic [4:0]  e5;
	logic [3:0]  e4;
	logic [1:0]  e2;

	output_channel_divider_mux i_output_channel_divider_mux (.*);

	always #25 core_clk = ~core_clk;

	// last divided period in cycles, and a running tick count
	always @(posedge core_clk) begin
		if (chan_tick === 1'b1) begin
			per <= cnt + 1;
			cnt <= 0;
			ntk <= ntk + 1;
		end else
			cnt <= cnt + 1;
	end

	// write: address and data together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 0;
		end while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 0;
	endtask

	// read: rready held until the answer edge
	task automatic rdr(input logic [11:0] a);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 0;
	endtask

	// wait for one divided tick, then one more edge so per has settled
	// and the caller drives inputs on an edge; the watchdog bounds a hang
	task automatic wt();
		do @(posedge core_clk); while (chan_tick !== 1'b1);
		@(posedge core_clk);
	endtask

	// skip the period in flight and the one after it, then check a whole one
	task automatic per_chk(input int e);
		wt();
		wt();
		wt();
		`CHK(per, e)
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// hang guard, far beyond the thousand or so cycles needed
	initial begin
		#2_000_000;
		miscompares++;
		conclude();
	end

	initial begin
		repeat (4) @(posedge core_clk);
		resetn <= 1;
		rdr(12'h0A0);
		`CHK(rd, 32'h0000_0002)
		rdr(12'h0A4);
		`CHK(rd, 32'h0000_0018)
		`CHK(tail_ma_q, 5'h08)
		$display("test reset values done");
		// ratios at both ends of the field, synthesizer one every cycle
		tk <= 4'h1;
		for (i = 0; i < 3; i++) begin
			wr(12'h0A0, dv[i], 4'hF);
			rdr(12'h0A0);
			`CHK(rd, dv[i])
			per_chk(dv[i] + 1);
		end
		wr(12'h0A0, 32'h0000_0005, 4'h0);
		rdr(12'h0A0);
		`CHK(rd, 32'h0000_00FF)
		$display("test divide ratios done");
		// rewrite mid-period: old period finishes whole
		wr(12'h0A0, 32'h0000_0007, 4'hF);
		per_chk(8);
		wr(12'h0A0, 32'h0000_0001, 4'hF);
		wt();
		`CHK(per, 8)
		wt();
		`CHK(per, 2)
		$display("test ratio change done");
		// each source: divided for synthesizers, straight for references
		wr(12'h0A0, 32'h0000_0002, 4'hF);
		for (i = 0; i < 4; i++) begin
			wr(12'h0A4, {24'h0, i[1:0], 6'h18}, 4'hF);
			tk <= 4'h1 << i;
			per_chk(i < 2 ? 3 : 1);
			tk <= ~(4'h1 << i);
			repeat (4) @(posedge core_clk);
			c = ntk;
			repeat (20) @(posedge core_clk);
			`CHK(ntk, c)
		end
		// status word: source in use and the ratio in force
		rdr(12'h0A8);
		`CHK(rd, 32'h0000_0302)
		$display("test source select done");
		// every format with every drive code, clock held still
		tk <= 4'h0;
		for (f = 0; f < 4; f++) begin
			for (c = 0; c < 4; c++) begin
				wr(12'h0A4, {24'h0, 2'b00, f[1:0], c[1:0], c[1:0]}, 4'hF);
				repeat (3) @(posedge core_clk);
				// tail per drive mode a, in the two differential formats only
				e5 = (c == 0) ? 5'h04 : (c == 1) ? 5'h06 : (c == 3 && f == 2) ? 5'h10 : 5'h08;
				if (f == 0 || f == 3)
					e5 = 5'h00;
				// pins: off when disabled, complementary in differential, per code in lvcmos
				e4 = (f == 3) ? {c != 0, c > 1, c != 0, c > 1} : {4{f != 0}};
				e2 = (f == 0) ? 2'b00 : (f != 3) ? {chan_level_q, ~chan_level_q} :
					{2{c == 3 ? chan_level_q : c == 2 ? ~chan_level_q : 1'b0}};
				`CHK(tail_ma_q, e5)
				`CHK(load_ohm_q, f == 2 ? ld[c] : 8'h00)
				`CHK({pin_p_oe_q, pin_p_pwr_q, pin_n_oe_q, pin_n_pwr_q}, e4)
				`CHK({pin_p_out_q, pin_n_out_q}, e2)
			end
		end
		$display("test driver decode done");
		// unmapped word: refused both ways
		wr(12'h0FC, 32'h0000_00FF, 4'hF);
		`CHK(rsp, 2'h2)
		rdr(12'h0FC);
		`CHK({rsp, rd}, {2'h2, 32'h0000_0000})
		$display("test unmapped done");
		conclude();
	end
endmodule // output_channel_divider_mux_tb_top
`default_nettype wire
